// [rtl/sprc_seq.sv]
// reset sequencer for a shared transceiver, one engine per direction
// assumes reset inputs and pll lock arrive asynchronously; apb on clk
//
// Overview of operation
// R1 - tx datapath reset runs a tx-only datapath sequence, then raises tx done
// R2 - rx datapath reset runs an rx-only datapath sequence, then raises rx done
// R3 - a system reset resets the direction's pll and datapath, then raises done
// R4 - tx and rx engines are fully independent of each other
// R5 - sequencers run on the auxiliary reconfiguration-port clock
// R6 - 32-bit build: core clock is line rate divided by forty
// R7 - 64-bit build: 64 data bits plus 2-bit header, line rate over sixty-six
// R8 - 64-bit core clock comes from outside, same source as reference clock
// R9 - 64-bit build pairs only with 64b/66b; 32-bit only with 8b/10b core
// R10 - shared pll port reachable only via management bus with quad pll chosen
// R11 - newer family with bus and quad pll exposes both reference clocks
// R12 - surrounding design supplies two refclks when two plls are selected
// R13 - management bus clock is asynchronous; crossings handled inside (here apb runs on clk, no crossing)
// R14 - without shared logic no shared pll nor its control registers
// R15 - with bus and debug, debug ports omit bus-controlled signals
// R16 - as a sub-block the management bus is forced off
// R17 - done drops at once on any reset request, rises when sequence ends (here done drops three clocks after a pin request)
`timescale 1ns/10ps
`default_nettype none
module sprc_seq
    import sprc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        transmit_datapath_reset_in,
    input  wire logic        tx_sys_reset_in,
    input  wire logic        receive_datapath_reset_in,
    input  wire logic        rx_sys_reset_in,
    input  wire logic        tx_pll_lock_in,
    input  wire logic        rx_pll_lock_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             tx_reset_done,
    output logic             rx_reset_done,
    output logic             tx_pll_reset_out,
    output logic             tx_datapath_reset_out,
    output logic             rx_pll_reset_out,
    output logic             rx_datapath_reset_out,
    output logic             quad_shared_pll_port_en,
    output logic             both_refclk_en,
    output logic             debug_bus_signals_en,
    output logic [7:0]       core_clk_div
);
    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [3:0]  sw_req;
        logic [5:0]  cfg;
        sprc_dir_t   tx;
        sprc_dir_t   rx;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        qport;
        logic        brefclk;
        logic        dbgbus;
        logic [7:0]  div;
    } sprc_regs_t;

    sprc_regs_t q_r;
    sprc_regs_t q_nxt;

    // one engine step; a system request restarts from the pll stage, a datapath request from the datapath stage unless a pll sequence runs
    function automatic sprc_dir_t step(input sprc_dir_t d, input logic dp_req,
                                       input logic sys_req, input logic lock);
        sprc_dir_t n;
        n = d;
        if (sys_req) begin // see R3
            n.state   = SPRC_PLL_RST;
            n.cnt     = SPRC_PLL_RST_CYC;
            n.done    = 1'b0; // see R17
            n.pll_rst = 1'b1;
            n.dp_rst  = 1'b1;
        end else if (dp_req && (d.state == SPRC_PLL_RST || d.state == SPRC_PLL_WT)) begin
            // a datapath request inside a pll sequence must not cut it short
            n.done    = 1'b0; // see R17
            n.dp_rst  = 1'b1;
        end else if (dp_req) begin // see R1 see R2
            n.state   = SPRC_DP_RST;
            n.cnt     = SPRC_DP_RST_CYC;
            n.done    = 1'b0; // see R17
            n.dp_rst  = 1'b1;
            n.pll_rst = d.pll_rst;
        end else begin
            case (d.state)
                SPRC_IDLE: begin
                    n.done = 1'b1;
                end
                SPRC_PLL_RST: begin
                    if (d.cnt == 8'h00) begin
                        n.pll_rst = 1'b0;
                        n.state   = SPRC_PLL_WT;
                        n.cnt     = SPRC_PLL_LOCK_CYC;
                    end else begin
                        n.cnt = d.cnt - 8'h01;
                    end
                end
                SPRC_PLL_WT: begin
                    // lock or timeout; a dead pll must not hang the link forever
                    if (lock || d.cnt == 8'h00) begin
                        n.state = SPRC_DP_RST;
                        n.cnt   = SPRC_DP_RST_CYC;
                    end else begin
                        n.cnt = d.cnt - 8'h01;
                    end
                end
                SPRC_DP_RST: begin
                    if (d.cnt == 8'h00) begin
                        n.dp_rst = 1'b0;
                        n.state  = SPRC_IDLE;
                        n.done   = 1'b1; // see R1 see R2 see R3
                    end else begin
                        n.cnt = d.cnt - 8'h01;
                    end
                end
                default: begin
                    n.state = SPRC_IDLE;
                end
            endcase
        end
        return n;
    endfunction

    // bus shares clk here, so no crossing is needed on it, see R13
    logic [5:0] sync_in;
    assign sync_in = {rx_pll_lock_in, tx_pll_lock_in, rx_sys_reset_in,
                      receive_datapath_reset_in, tx_sys_reset_in,
                      transmit_datapath_reset_in};

    always_comb begin
        logic [5:0]  cfg_w;
        logic        wr;
        logic        rd;
        cfg_w = 6'h00;
        wr = 1'b0;
        rd = 1'b0;
        q_nxt = q_r;
        q_nxt.s1 = sync_in;
        q_nxt.s2 = q_r.s1;
        q_nxt.sw_req = 4'h0;
        q_nxt.pready = 1'b0;
        q_nxt.pslverr = 1'b0;
        wr = psel && penable && !q_r.pready && pwrite;
        rd = psel && penable && !q_r.pready && !pwrite;
        if (psel && penable && !q_r.pready) begin
            q_nxt.pready = 1'b1;
            q_nxt.prdata = 32'h0000_0000;
            case (paddr)
                SPRC_CTRL_OFS: begin
                    if (wr) begin
                        q_nxt.sw_req = pwdata[3:0];
                    end
                end
                SPRC_STAT_OFS: begin
                    q_nxt.prdata = {24'h00_0000, q_r.rx.pll_rst, q_r.rx.dp_rst,
                                    q_r.tx.pll_rst, q_r.tx.dp_rst, 2'b00,
                                    q_r.rx.done, q_r.tx.done};
                end
                SPRC_CFG_OFS: begin
                    if (wr) begin
                        cfg_w = pwdata[5:0];
                        // a sub-block build cannot turn the bus on, see R16
                        if (cfg_w[SPRC_SUBCORE_BIT]) begin
                            cfg_w[SPRC_MGMT_BIT] = 1'b0;
                        end
                        q_nxt.cfg = cfg_w;
                    end
                    q_nxt.prdata = {26'h000_0000, q_r.cfg};
                end
                SPRC_BUILD_OFS: begin
                    q_nxt.prdata = {24'h00_0000, q_r.div};
                end
                default: begin
                    q_nxt.pslverr = 1'b1;
                end
            endcase
            if (rd && paddr == SPRC_CFG_OFS) begin
                q_nxt.prdata = {26'h000_0000, q_r.cfg};
            end
        end
        // engines share nothing but the clock and reset, see R4 see R5
        q_nxt.tx = step(q_r.tx, q_r.s2[0] | q_r.sw_req[SPRC_TX_DP_BIT],
                        q_r.s2[1] | q_r.sw_req[SPRC_TX_SYS_BIT], q_r.s2[4]);
        q_nxt.rx = step(q_r.rx, q_r.s2[2] | q_r.sw_req[SPRC_RX_DP_BIT],
                        q_r.s2[3] | q_r.sw_req[SPRC_RX_SYS_BIT], q_r.s2[5]);
        // build options
        // width bit also fixes the line code pairing, see R9
        q_nxt.div = q_r.cfg[SPRC_W64_BIT] ? SPRC_LINE_DIV64 : SPRC_LINE_DIV32; // see R6 see R7
        q_nxt.qport = q_r.cfg[SPRC_MGMT_BIT] && q_r.cfg[SPRC_QUAD_BIT]
                      && q_r.cfg[SPRC_SHARED_BIT]; // see R10 see R14
        q_nxt.brefclk = q_r.cfg[SPRC_MGMT_BIT] && q_r.cfg[SPRC_QUAD_BIT]; // see R11
        q_nxt.dbgbus = q_r.cfg[SPRC_DEBUG_BIT] && !q_r.cfg[SPRC_MGMT_BIT]; // see R15
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q_r <= '0;
            q_r.cfg <= SPRC_CFG_RESET;
            q_r.tx.state <= SPRC_IDLE;
            q_r.rx.state <= SPRC_IDLE;
            q_r.div <= SPRC_LINE_DIV32;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pready                = q_r.pready;
    assign pslverr               = q_r.pslverr;
    assign prdata                = q_r.prdata;
    assign tx_reset_done         = q_r.tx.done;
    assign rx_reset_done         = q_r.rx.done;
    assign tx_pll_reset_out      = q_r.tx.pll_rst;
    assign tx_datapath_reset_out = q_r.tx.dp_rst;
    assign rx_pll_reset_out      = q_r.rx.pll_rst;
    assign rx_datapath_reset_out = q_r.rx.dp_rst;
    assign quad_shared_pll_port_en = q_r.qport;
    assign both_refclk_en        = q_r.brefclk;
    assign debug_bus_signals_en  = q_r.dbgbus;
    assign core_clk_div          = q_r.div;
endmodule
`default_nettype wire

// [rtl/sprc_pkg.sv]
// constants and types for the transceiver reset sequencer
// assumes a 20 MHz aux clock and an APB master on the same clock
package sprc_pkg;
    localparam logic [11:0] SPRC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] SPRC_STAT_OFS   = 12'h004;
    localparam logic [11:0] SPRC_CFG_OFS    = 12'h008;
    localparam logic [11:0] SPRC_BUILD_OFS  = 12'h00C;
    // ctrl bit positions
    localparam int SPRC_TX_DP_BIT  = 0;
    localparam int SPRC_TX_SYS_BIT = 1;
    localparam int SPRC_RX_DP_BIT  = 2;
    localparam int SPRC_RX_SYS_BIT = 3;
    // cfg bit positions
    localparam int SPRC_W64_BIT    = 0;
    localparam int SPRC_MGMT_BIT   = 1;
    localparam int SPRC_SHARED_BIT = 2;
    localparam int SPRC_QUAD_BIT   = 3;
    localparam int SPRC_DEBUG_BIT  = 4;
    localparam int SPRC_SUBCORE_BIT = 5;
    localparam logic [5:0] SPRC_CFG_RESET = 6'h04;
    // timing, figures in ns
    localparam int SPRC_CLK_NS      = 50;
    localparam int SPRC_PLL_RST_NS  = 1000;
    localparam int SPRC_PLL_LOCK_NS = 5000;
    localparam int SPRC_DP_RST_NS   = 500;
    localparam logic [7:0] SPRC_PLL_RST_CYC =
        8'((SPRC_PLL_RST_NS + SPRC_CLK_NS - 1) / SPRC_CLK_NS);
    localparam logic [7:0] SPRC_PLL_LOCK_CYC =
        8'((SPRC_PLL_LOCK_NS + SPRC_CLK_NS - 1) / SPRC_CLK_NS);
    localparam logic [7:0] SPRC_DP_RST_CYC =
        8'((SPRC_DP_RST_NS + SPRC_CLK_NS - 1) / SPRC_CLK_NS);
    localparam logic [7:0] SPRC_LINE_DIV32 = 8'h28;
    localparam logic [7:0] SPRC_LINE_DIV64 = 8'h42;

    typedef enum logic [3:0] {
        SPRC_IDLE    = 4'b0001,
        SPRC_PLL_RST = 4'b0010,
        SPRC_PLL_WT  = 4'b0100,
        SPRC_DP_RST  = 4'b1000
    } sprc_state_t;

    typedef struct packed {
        sprc_state_t state;
        logic [7:0]  cnt;
        logic        done;
        logic        pll_rst;
        logic        dp_rst;
    } sprc_dir_t;
endpackage

// [verif/sprc_pll_model.sv]
// stand-in for a transceiver pll and its reference clock
// assumes the sequencer's pll reset output, one clock
`timescale 1ns/10ps
`default_nettype none
module sprc_pll_model #(
    parameter int LOCK_DLY = 30
) (
    input  wire logic clk,
    input  wire logic pll_reset,
    output logic      lock
);
    logic [7:0] cnt_r = 8'h00;
    // lock only after a settling count, never at once
    always_ff @(posedge clk) begin
        if (pll_reset)
            cnt_r <= 8'h00;
        else if (cnt_r < 8'(LOCK_DLY))
            cnt_r <= cnt_r + 8'h01;
    end
    assign lock = (cnt_r == 8'(LOCK_DLY)) && !pll_reset;
endmodule
`default_nettype wire

// [verif/sprc_seq_asserts.sv]
// timing relations of the reset sequencer outputs
// assumes it is bound onto sprc_seq, single clock domain
`timescale 1ns/10ps
`default_nettype none
module sprc_seq_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        transmit_datapath_reset_in,
    input wire logic        rx_sys_reset_in,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        tx_reset_done,
    input wire logic        rx_reset_done,
    input wire logic        tx_pll_reset_out,
    input wire logic        tx_datapath_reset_out,
    input wire logic        rx_datapath_reset_out,
    input wire logic [7:0]  core_clk_div
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_tx_req;
        $rose(transmit_datapath_reset_in);
    endsequence
    sequence s_tx_end;
        $fell(tx_datapath_reset_out) && !tx_pll_reset_out;
    endsequence
    a_tx_dp_blocks: assert property (tx_datapath_reset_out |-> !tx_reset_done)
        else $error("tx done high in datapath reset");
    a_rx_dp_blocks: assert property (rx_datapath_reset_out |-> !rx_reset_done)
        else $error("rx done high in datapath reset");
    a_tx_pll_blocks: assert property (tx_pll_reset_out |-> !tx_reset_done)
        else $error("tx done high in pll reset");
    a_tx_req_drop: assert property (s_tx_req |-> ##[1:4] !tx_reset_done)
        else $error("tx done not dropped");
    a_rx_sys_drop: assert property ($rose(rx_sys_reset_in) |-> ##[1:4] !rx_reset_done)
        else $error("rx done not dropped");
    a_tx_end_done: assert property (s_tx_end |-> ##[0:2] tx_reset_done)
        else $error("tx done late");
    a_div_legal: assert property (core_clk_div == 8'h28 || core_clk_div == 8'h42)
        else $error("bad divider");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response carries data");
endmodule
bind sprc_seq sprc_seq_asserts u_chk (.clk, .reset, .transmit_datapath_reset_in,
    .rx_sys_reset_in, .pready, .pslverr, .prdata, .tx_reset_done, .rx_reset_done,
    .tx_pll_reset_out, .tx_datapath_reset_out, .rx_datapath_reset_out, .core_clk_div);
`default_nettype wire

// [verif/testbench.sv]
// bench for the reset sequencer: apb tasks, pin and register resets
// assumes pll models on both directions, 50 ns clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sprc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  rst_in = 4'h0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q, prdata;
    logic        pready, pslverr, e, quad_en, ref_en, dbg_en, ol, sp;
    logic [1:0]  dn, pll_o, dp_o, lock;
    logic [7:0]  div;
    int          n_fail = 0, checks = 0, cyc = 0, i, dir;
    always #25 clk = ~clk;
    sprc_seq uut (.clk, .reset, .transmit_datapath_reset_in(rst_in[0]),
        .tx_sys_reset_in(rst_in[1]), .receive_datapath_reset_in(rst_in[2]),
        .rx_sys_reset_in(rst_in[3]), .tx_pll_lock_in(lock[0]), .rx_pll_lock_in(lock[1]),
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .tx_reset_done(dn[0]), .rx_reset_done(dn[1]), .tx_pll_reset_out(pll_o[0]),
        .tx_datapath_reset_out(dp_o[0]), .rx_pll_reset_out(pll_o[1]),
        .rx_datapath_reset_out(dp_o[1]), .quad_shared_pll_port_en(quad_en),
        .both_refclk_en(ref_en), .debug_bus_signals_en(dbg_en), .core_clk_div(div));
    sprc_pll_model pll_tx (.clk, .pll_reset(pll_o[0]), .lock(lock[0]));
    sprc_pll_model pll_rx (.clk, .pll_reset(pll_o[1]), .lock(lock[1]));
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cfg(input logic [31:0] v, input logic [10:0] x);
        apb(1'b1, 12'h008, v);
        repeat (2) @(posedge clk);
        chk("cfg outputs", 32'({quad_en, ref_en, dbg_en, div}), 32'(x));
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("stat", q, 32'h0000_0003);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("build", q, 32'h0000_0028);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", {q[30:0], e}, 32'h0000_0001);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            i = k % 4;
            dir = i / 2;
            if (k < 4) begin
                rst_in[i] <= 1'b1;
                repeat (3) @(posedge clk);
                rst_in[i] <= 1'b0;
            end else
                apb(1'b1, 12'h000, 32'(1 << i));
            repeat (4) @(posedge clk);
            chk("done low", 32'(dn[dir]), 32'h0000_0000);
            ol = 1'b0;
            sp = 1'b0;
            for (int c = 0; c < 400 && dn[dir] !== 1'b1; c++) begin
                @(posedge clk);
                ol |= dn[1 - dir] !== 1'b1;
                sp |= pll_o[dir];
            end
            chk("sequence", 32'({sp, ol, dn[dir]}), 32'({i[0], 2'b01}));
            $display("test reset sequence %0d done", k);
        end
        cfg(32'h0000_000F, {3'b110, 8'h42});
        cfg(32'h0000_0001, {3'b000, 8'h42});
        cfg(32'h0000_0012, {3'b000, 8'h28});
        cfg(32'h0000_0010, {3'b001, 8'h28});
        cfg(32'h0000_002E, {3'b000, 8'h28});
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("subcore cfg", q, 32'h0000_002C);
        $display("test configuration done");
        wrap_up();
    end
endmodule
`default_nettype wire
